// *** hdl/adc_result_pkg.sv ***
// shared constants for the adc result and compare register slice
package adc_result_pkg;
	localparam int addr_width = 8;
	localparam int data_width = 32;
	localparam int value_width = 10;
	localparam int value_lsb = 6;
	localparam int value_msb = 15;
	localparam int stored_bit = 0;
	localparam int overrun_bit = 1;
	// register byte offsets
	localparam logic [7:0] slot7_result_offset = 8'h00;
	localparam logic [7:0] priority_result_offset = 8'h04;
	localparam logic [7:0] monitor0_threshold_offset = 8'h08;
	localparam logic [7:0] monitor0_mode_offset = 8'h0c;
	localparam logic [7:0] irq_status_offset = 8'h10;
	localparam logic [7:0] irq_mask_offset = 8'h14;
	// monitor0 mode register fields
	localparam int mode_select_lsb = 0;
	localparam int mode_select_msb = 2;
	localparam int mode_direction_bit = 3;
	localparam int mode_enable_bit = 4;
	// interrupt status bits
	localparam int irq_monitor0_bit = 0;
	localparam int irq_slot7_overrun_bit = 1;
	localparam int irq_priority_overrun_bit = 2;
	localparam int irq_width = 3;
	// result-select codes seen by monitor0
	localparam logic [2:0] select_slot7 = 3'h7;
	localparam logic [2:0] select_priority = 3'h0;
	localparam logic [31:0] reset_word = 32'h0000_0000;
	localparam logic [9:0] reset_value = 10'h000;
	localparam logic [2:0] reset_irq = 3'h0;
	localparam logic [4:0] reset_mode = 5'h00;
endpackage

// *** hdl/result_slot.sv ***
// one conversion result holder with stored and overrun flags
`timescale 1ns/100ps
`default_nettype none
module result_slot
	import adc_result_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic store_i,
	input wire logic [adc_result_pkg::value_width-1:0] value_i,
	input wire logic read_i,
	output logic [adc_result_pkg::value_width-1:0] value_o,
	output logic stored_o,
	output logic overrun_o,
	output logic overrun_event_o
);
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			value_o <= reset_value;
		end else if (store_i) begin
			value_o <= value_i;
		end
	end

	// store sets flag; set wins over the read clear
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stored_o <= 1'b0;
		end else if (store_i) begin
			stored_o <= 1'b1;
		end else if (read_i) begin
			stored_o <= 1'b0;
		end
	end

	// overwrite of unread value sets overrun
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			overrun_o <= 1'b0;
		end else if (store_i && stored_o && !read_i) begin
			// both flags stay set while overwritten
			overrun_o <= 1'b1;
		end else if (read_i) begin
			overrun_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			overrun_event_o <= 1'b0;
		end else begin
			overrun_event_o <= store_i && stored_o && !read_i;
		end
	end

	a_overrun_set: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		(store_i && stored_o && !read_i) |=> overrun_o && stored_o)
		else $error("overrun not set on overwrite");
	a_stored_clear: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		(read_i && !store_i) |=> !stored_o && !overrun_o)
		else $error("flags not cleared by read");
	a_value_load: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i)
		store_i |=> stored_o && value_o == $past(value_i))
		else $error("value or stored flag wrong after store");
endmodule
`default_nettype wire

// *** hdl/adc_result_compare_regs.sv ***
// result registers, monitor0 threshold and compare, interrupt status
//
// Operation
// - Each result register shows its 10-bit value in bits 15:6, its flags in bits 1:0 and zeros elsewhere.
// - The priority result register takes only top-priority conversion results.
// - Storing a new value sets that register's stored flag in bit 0.
// - Reading a result register clears its stored flag.
// - Storing over an unread value sets the overrun flag in bit 1.
// - Reading the register clears its overrun flag.
// - The monitor0 threshold is a 10-bit read/write field in bits 15:6, compared with the selected result.
// - Monitor0 compares on each store to the selected register and fires by direction.
// - Repeated overwrites leave stored and overrun flags both set.
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module adc_result_compare_regs
	import adc_result_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [adc_result_pkg::addr_width-1:0] addr_i,
	input wire logic [adc_result_pkg::data_width-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [adc_result_pkg::data_width-1:0] rdata_o,
	input wire logic slot7_store_i,
	input wire logic priority_store_i,
	input wire logic [adc_result_pkg::value_width-1:0] conv_value_i,
	output logic monitor0_irq_o,
	output logic irq_o
);
	import adc_result_pkg::*;

	logic [value_width-1:0] slot7_value;
	logic slot7_stored_flag;
	logic slot7_overrun_flag;
	logic slot7_overrun_event;
	logic [value_width-1:0] priority_value;
	logic priority_stored_flag;
	logic priority_overrun_flag;
	logic priority_overrun_event;
	logic [value_width-1:0] monitor0_threshold_value;
	logic [4:0] monitor0_mode_reg;
	logic [irq_width-1:0] irq_status;
	logic [irq_width-1:0] irq_mask;
	logic [irq_width-1:0] irq_events;
	logic monitor0_hit;
	logic slot7_read;
	logic priority_read;
	logic [data_width-1:0] next_rdata;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	function automatic logic [data_width-1:0] result_word(input logic [value_width-1:0] v,
		input logic ovr, input logic st);
		logic [data_width-1:0] w;
		w = reset_word;
		w[value_msb:value_lsb] = v;
		w[overrun_bit] = ovr;
		w[stored_bit] = st;
		result_word = w;
	endfunction

	// a read of the register is the clearing read
	assign slot7_read = rd_i && hit(addr_i, slot7_result_offset);
	assign priority_read = rd_i && hit(addr_i, priority_result_offset);

	// slot7 word always presented whole, so 16/32-bit reads see the flags
	result_slot slot7_u (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.store_i(slot7_store_i),
		.value_i(conv_value_i),
		.read_i(slot7_read),
		.value_o(slot7_value),
		.stored_o(slot7_stored_flag),
		.overrun_o(slot7_overrun_flag),
		.overrun_event_o(slot7_overrun_event)
	);

	// only the top-priority store strobe feeds this slot
	result_slot priority_u (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.store_i(priority_store_i),
		.value_i(conv_value_i),
		.read_i(priority_read),
		.value_o(priority_value),
		.stored_o(priority_stored_flag),
		.overrun_o(priority_overrun_flag),
		.overrun_event_o(priority_overrun_event)
	);

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			monitor0_threshold_value <= reset_value;
		end else if (wr_i && hit(addr_i, monitor0_threshold_offset)) begin
			// written regardless; software keeps monitor0 off meanwhile
			monitor0_threshold_value <= wdata_i[value_msb:value_lsb];
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			monitor0_mode_reg <= reset_mode;
		end else if (wr_i && hit(addr_i, monitor0_mode_offset)) begin
			monitor0_mode_reg <= wdata_i[4:0];
		end
	end

	// compare the incoming value as it is stored in the selected slot
	always_comb begin
		monitor0_hit = 1'b0;
		if (monitor0_mode_reg[mode_enable_bit]) begin
			if ((monitor0_mode_reg[mode_select_msb:mode_select_lsb] == select_slot7 &&
				slot7_store_i) ||
				(monitor0_mode_reg[mode_select_msb:mode_select_lsb] == select_priority &&
				priority_store_i)) begin
				if (monitor0_mode_reg[mode_direction_bit]) begin
					monitor0_hit = conv_value_i > monitor0_threshold_value;
				end else begin
					monitor0_hit = conv_value_i < monitor0_threshold_value;
				end
			end
		end
	end

	assign irq_events = {priority_overrun_event, slot7_overrun_event, monitor0_hit};

	// sticky status: the event wins over a write-one clear in the same cycle
	genvar g;
	generate
		for (g = 0; g < irq_width; g++) begin : status_bits
			always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					irq_status[g] <= 1'b0;
				end else if (irq_events[g]) begin
					irq_status[g] <= 1'b1;
				end else if (wr_i && hit(addr_i, irq_status_offset) && wdata_i[g]) begin
					irq_status[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_mask <= reset_irq;
		end else if (wr_i && hit(addr_i, irq_mask_offset)) begin
			irq_mask <= wdata_i[irq_width-1:0];
		end
	end

	// outputs registered; irq_o one cycle after the status bit, monitor0_irq_o on the same edge as it
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
			monitor0_irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_mask);
			monitor0_irq_o <= monitor0_hit;
		end
	end

	// read mux; unmapped and reserved bits read zero
	always_comb begin
		next_rdata = reset_word;
		case (addr_i)
			slot7_result_offset: begin
				next_rdata = result_word(slot7_value, slot7_overrun_flag, slot7_stored_flag);
			end
			priority_result_offset: begin
				next_rdata = result_word(priority_value, priority_overrun_flag,
					priority_stored_flag);
			end
			monitor0_threshold_offset: begin
				next_rdata[value_msb:value_lsb] = monitor0_threshold_value;
			end
			monitor0_mode_offset: begin
				next_rdata[4:0] = monitor0_mode_reg;
			end
			irq_status_offset: begin
				next_rdata[irq_width-1:0] = irq_status;
			end
			irq_mask_offset: begin
				next_rdata[irq_width-1:0] = irq_mask;
			end
			default: begin
				next_rdata = reset_word;
			end
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= reset_word;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= reset_word;
		end
	end

	a_result_layout: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) rd_i && hit(addr_i, slot7_result_offset) |=>
		rdata_o[31:16] == 16'h0000 && rdata_o[5:2] == 4'h0)
		else $error("reserved result bits not zero");
	a_priority_layout: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) rd_i && hit(addr_i, priority_result_offset) |=>
		rdata_o[31:16] == 16'h0000 && rdata_o[5:2] == 4'h0)
		else $error("reserved priority bits not zero");
	a_priority_only: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) (!priority_store_i) |=> $stable(priority_value))
		else $error("priority value changed without priority store");
	a_threshold_read: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) wr_i && hit(addr_i, monitor0_threshold_offset) ##1 rd_i &&
		hit(addr_i, monitor0_threshold_offset) && !wr_i |=>
		rdata_o[value_msb:value_lsb] == $past(wdata_i[value_msb:value_lsb], 2) &&
		rdata_o[5:0] == 6'h00)
		else $error("threshold readback wrong");
	a_threshold_keep: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) !(wr_i && hit(addr_i, monitor0_threshold_offset)) |=>
		$stable(monitor0_threshold_value))
		else $error("threshold changed without write");
	a_monitor_fire: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) monitor0_mode_reg[mode_enable_bit] && slot7_store_i &&
		monitor0_mode_reg[mode_select_msb:mode_select_lsb] == select_slot7 &&
		monitor0_mode_reg[mode_direction_bit] && conv_value_i > monitor0_threshold_value
		|=> monitor0_irq_o ##1 irq_status[irq_monitor0_bit])
		else $error("monitor0 did not fire");
	a_monitor_small: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) monitor0_mode_reg[mode_enable_bit] && priority_store_i &&
		monitor0_mode_reg[mode_select_msb:mode_select_lsb] == select_priority &&
		!monitor0_mode_reg[mode_direction_bit] && conv_value_i < monitor0_threshold_value
		|=> monitor0_irq_o ##1 irq_status[irq_monitor0_bit])
		else $error("monitor0 did not fire on smaller value");
	a_monitor_quiet: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) !monitor0_mode_reg[mode_enable_bit] |=> !monitor0_irq_o)
		else $error("monitor0 fired while disabled");
	a_slot7_clear: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) slot7_read && !slot7_store_i |=> !slot7_stored_flag)
		else $error("slot7 stored flag survived read");
	a_priority_clear: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) priority_read && !priority_store_i |=> !priority_stored_flag)
		else $error("priority stored flag survived read");
	a_priority_overrun: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) priority_store_i && priority_stored_flag && !priority_read |=>
		priority_overrun_flag ##1 irq_status[irq_priority_overrun_bit])
		else $error("priority overrun not flagged");
	a_ovr_clear: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) priority_read && !priority_store_i |=> !priority_overrun_flag)
		else $error("priority overrun survived read");
	a_slot7_ovr_clear: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) slot7_read && !slot7_store_i |=> !slot7_overrun_flag)
		else $error("slot7 overrun survived read");
	a_ovr_keep: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) slot7_overrun_flag && slot7_stored_flag && !slot7_read |=>
		slot7_overrun_flag && slot7_stored_flag)
		else $error("flags dropped without read");
	a_ro_ignore: assert property (@(posedge core_clk_i)
		disable iff (sys_rst_i) wr_i && hit(addr_i, slot7_result_offset) && !slot7_store_i |=>
		$stable(slot7_value))
		else $error("result write not ignored");
	a_irq_level: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		|(irq_status & irq_mask) |=> irq_o)
		else $error("irq not raised");
	a_irq_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!(|(irq_status & irq_mask)) |=> !irq_o)
		else $error("irq raised without masked status");

	c_overrun: cover property (@(posedge core_clk_i) slot7_overrun_event);
	c_priority_overrun: cover property (@(posedge core_clk_i) priority_overrun_event);
	c_priority_read: cover property (@(posedge core_clk_i) priority_read && priority_stored_flag);
	c_monitor: cover property (@(posedge core_clk_i) monitor0_hit);
	c_irq: cover property (@(posedge core_clk_i) irq_o);
endmodule
`default_nettype wire

// *** test/conv_engine_model.sv ***
// conversion engine stand-in that issues store pulses
`timescale 1ns/100ps
`default_nettype none
module conv_engine_model (
	input wire logic core_clk_i,
	input wire logic start_i,
	input wire logic prio_i,
	input wire logic [9:0] val_i,
	output logic slot7_store_o,
	output logic priority_store_o,
	output logic [9:0] value_o
);
	always_ff @(posedge core_clk_i) begin
		// only top-priority results strobe the priority slot
		priority_store_o <= start_i & prio_i;
		slot7_store_o <= start_i & ~prio_i;
		// value is not held between stores, so a stale sample cannot pass
		value_o <= start_i ? val_i : ~value_o;
	end
endmodule
`default_nettype wire

// *** test/adc_result_compare_regs_tb.sv ***
// self-checking bench for the result and compare register slice
`timescale 1ns/100ps
`default_nettype none
module adc_result_compare_regs_tb;
	import adc_result_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0, rd = 1'b0, start = 1'b0, prio = 1'b0, rd_d = 1'b0;
	logic [9:0] val = 10'h0, conv_value, thr = 10'h0;
	logic slot7_store, priority_store, monitor0_irq, irq;
	logic [31:0] rdata, seed = 32'h90ad4f49;
	logic [31:0] exp_q[$];
	logic [9:0] rv[2] = '{10'h0, 10'h0};
	logic st[2] = '{1'b0, 1'b0};
	logic ov[2] = '{1'b0, 1'b0};
	logic [2:0] stat = 3'h0;
	logic mon_en = 1'b0, mon_dir = 1'b0, mon_p = 1'b0;
	int n_errors = 0, cmp_count = 0, pulses = 0, exp_pulses = 0;

	always #20 core_clk = ~core_clk;

	adc_result_compare_regs i_dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .slot7_store_i(slot7_store),
		.priority_store_i(priority_store), .conv_value_i(conv_value),
		.monitor0_irq_o(monitor0_irq), .irq_o(irq));
	conv_engine_model i_eng (.core_clk_i(core_clk), .start_i(start), .prio_i(prio),
		.val_i(val), .slot7_store_o(slot7_store), .priority_store_o(priority_store),
		.value_o(conv_value));

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge core_clk) begin
		if (rd_d)
			chk(rdata, exp_q.pop_front());
		if (monitor0_irq !== 1'b0)
			pulses++;
		rd_d <= rd;
	end

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		exp_q.push_back(e);
		@(posedge core_clk);
		rd <= 1'b0;
	endtask

	task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		rd <= 1'b0;
	endtask

	task automatic rd_res(input int k);
		rd_reg(k ? priority_result_offset : slot7_result_offset,
			{16'h0, rv[k], 4'h0, ov[k], st[k]});
		st[k] = 1'b0;
		ov[k] = 1'b0;
	endtask

	task automatic conv(input int k, input logic [9:0] v);
		@(posedge core_clk);
		start <= 1'b1;
		prio <= k[0];
		val <= v;
		@(posedge core_clk);
		start <= 1'b0;
		if (st[k])
			stat[k + 1] = 1'b1;
		ov[k] = ov[k] | st[k];
		st[k] = 1'b1;
		rv[k] = v;
		if (mon_en && mon_p == k[0] && (mon_dir ? v > thr : v < thr)) begin
			stat[0] = 1'b1;
			exp_pulses++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		n_errors++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int a = 0; a < 32; a += 4)
			rd_reg(a[7:0], 32'h0);
		$display("test reset done");
		for (int k = 0; k < 2; k++) begin
			seed = xs(seed);
			conv(k, seed[9:0]);
			rd_res(1 - k);
			rd_res(k);
			rd_res(k);
			seed = xs(seed);
			conv(k, seed[9:0]);
			seed = xs(seed);
			conv(k, seed[9:0]);
			wr_reg(slot7_result_offset + 8'(4 * k), 32'hffffffff);
			rd_res(k);
			rd_res(k);
		end
		rd_reg(irq_status_offset, {29'h0, stat});
		$display("test results done");
		wr_rd(monitor0_threshold_offset, 32'hffffffff, 32'h0000ffc0);
		for (int m = 0; m < 2; m++) begin
			mon_en = 1'b0;
			wr_reg(monitor0_mode_offset, 32'h0);
			thr = 10'h100;
			wr_reg(monitor0_threshold_offset, {16'h0, thr, 6'h0});
			mon_p = m[0];
			mon_dir = ~m[0];
			mon_en = 1'b1;
			wr_reg(monitor0_mode_offset,
				{27'h0, 1'b1, ~m[0], m[0] ? select_priority : select_slot7});
			conv(m, 10'h101);
			conv(m, 10'h100);
			conv(m, 10'h0ff);
			// the unselected slot would hit if the selection were ignored
			conv(1 - m, m ? 10'h000 : 10'h3ff);
		end
		repeat (3) @(posedge core_clk);
		chk(pulses, exp_pulses);
		rd_reg(irq_status_offset, {29'h0, stat});
		$display("test monitor done");
		wr_reg(irq_mask_offset, 32'h0);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr_reg(irq_mask_offset, 32'h7);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, {31'h0, |stat});
		wr_reg(irq_status_offset, 32'h7);
		stat = 3'h0;
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		rd_reg(irq_status_offset, 32'h0);
		rd_reg(irq_mask_offset, 32'h7);
		repeat (4) @(posedge core_clk);
		$display("test interrupt done");
		test_done();
	end
endmodule
`default_nettype wire
